//--- psc_pkg.sv
// Package for the startup configuration register bank
package psc_pkg;

   // Printed offsets are not all multiples of four: kept as indices, byte address is four times the index
   localparam logic [11:0] IDX_SUPPLY_FAULT_THRESHOLD   = 12'h0107;
   localparam logic [11:0] IDX_BUCK_CLOCK_AND_TRACKING  = 12'h0108;
   localparam logic [11:0] IDX_OUTPUT_AND_IF_CONTROL    = 12'h0109;
   localparam logic [11:0] IDX_BUCK_SWITCH_AUTOENABLE   = 12'h010a;
   localparam logic [11:0] IDX_LINEAR_BYPASS_AUTOENABLE = 12'h010b;
   localparam logic [11:0] IDX_LINEAR_AUTOENABLE_LOW    = 12'h010c;
   localparam int          ADDR_LSB                     = 2;
   localparam int          ADDR_W                       = 14;

   localparam logic [7:0]  RST_SUPPLY_FAULT_THRESHOLD   = 8'h00;
   localparam logic [7:0]  RST_BUCK_CLOCK_AND_TRACKING  = 8'h00;
   localparam logic [7:0]  RST_OUTPUT_AND_IF_CONTROL    = 8'h00;
   localparam logic [7:0]  RST_BUCK_SWITCH_AUTOENABLE   = 8'h00;
   localparam logic [7:0]  RST_LINEAR_BYPASS_AUTOENABLE = 8'h00;
   localparam logic [7:0]  RST_LINEAR_AUTOENABLE_LOW    = 8'h00;

   // Field positions
   localparam int HYST_HI = 6;
   localparam int HYST_LO = 4;
   localparam int LOWER_HI = 3;
   localparam int LOWER_LO = 0;
   localparam int CLKINV_HI = 7;
   localparam int CLKINV_LO = 3;
   localparam int CORE1_INV_BIT = 3;
   localparam int DISCHARGE_BIT = 2;
   localparam int TRACK_HI = 1;
   localparam int TRACK_LO = 0;
   localparam int FB3_POL_BIT = 7;
   localparam int FB2_POL_BIT = 6;
   localparam int FORCE_RESET_BIT = 5;
   localparam int HSM_BIT = 4;
   localparam int FMP_BIT = 3;
   localparam int SYSEN_KEEP_BIT = 2;
   localparam int IRQ_DEFER_BIT = 1;
   localparam int BYPASS_HI = 7;
   localparam int BYPASS_LO = 3;
   localparam int LIN_HI_AUTO_HI = 2;
   localparam int LIN_HI_AUTO_LO = 0;

   // Threshold steps in millivolts
   localparam logic [11:0] HYST_BASE_MV   = 12'd100;
   localparam logic [11:0] LOWER_BASE_MV  = 12'd2500;
   localparam logic [11:0] STEP_MV        = 12'd50;

   typedef enum logic [1:0] {TRK_NONE, TRK_PRO, TRK_CORE1, TRK_CORE2} psc_track_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } psc_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } psc_apb_rsp_t;

endpackage

//--- psc_config_bank.sv
// Startup configuration register bank with APB slave and decoded controls
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module psc_config_bank
   import psc_pkg::*;
(
   input  wire logic         CORE_CLK,
   input  wire logic         RSTN,
   input  wire psc_apb_req_t APB_REQ,
   output logic              PREADY,
   output logic              PSLVERR,
   output logic [31:0]       PRDATA,
   // Live status from the power sequencer
   input  wire logic         POWERING_UP,
   input  wire logic         LOW_POWER_STATE,
   input  wire logic         OTP_SECOND_READ,
   input  wire logic         OTP_SYSTEM_EN,
   input  wire logic         IRQ_EVENT,
   input  wire logic         FEEDBACK_OUT2_RAW,
   input  wire logic         FEEDBACK_OUT3_RAW,
   input  wire logic [7:0]   BUCK_SWITCH_CONF_EN,
   input  wire logic [10:0]  LINEAR_CONF_EN,
   // Analog and pin controls
   output logic [11:0]       FAULT_HYSTERESIS_MV,
   output logic [11:0]       FAULT_LOWER_THRESHOLD_MV,
   output logic [5:0]        BUCK_CLOCK_INVERT,
   output logic              RAIL_DISCHARGE_ENABLE,
   output psc_track_t        LINEAR1_TRACKING_SELECT,
   output logic              FEEDBACK_OUT3,
   output logic              FEEDBACK_OUT2_O,
   output logic              FEEDBACK_OUT2_OE,
   output logic              SYSTEM_RESET_OUT_N,
   output logic              SECOND_BUS_HIGHSPEED_CONTINUOUS,
   output logic              SECOND_BUS_FASTPLUS_SELECT,
   output logic              SYSTEM_EN,
   output logic              INTERRUPT_OUT,
   output logic [7:0]        BUCK_SWITCH_ENABLE,
   output logic [4:0]        LINEAR_BYPASS_SELECT,
   output logic [10:0]       LINEAR_ENABLE
);

   function automatic logic [11:0] code_to_mv(input logic [11:0] base, input logic [3:0] code);
      code_to_mv = base + 12'(code) * STEP_MV;
   endfunction

   logic [7:0]  thr_q, thr_d;
   logic [7:0]  clk_q, clk_d;
   logic [7:0]  out_q, out_d;
   logic [7:0]  bsw_q, bsw_d;
   logic [7:0]  lbp_q, lbp_d;
   logic [7:0]  llo_q, llo_d;
   logic        sysen_q, sysen_d;
   logic        irq_pend_q, irq_pend_d;
   logic        irq_out_q, irq_out_d;
   logic [31:0] rdata_q, rdata_d;

   // APB decode; the slave answers in the access cycle, no wait states
   wire              setup_ok  = APB_REQ.psel & ~APB_REQ.penable;
   wire              access    = APB_REQ.psel & APB_REQ.penable;
   wire [ADDR_W-1:0] word_idx  = APB_REQ.paddr[ADDR_W+ADDR_LSB-1:ADDR_LSB];
   wire              aligned   = (APB_REQ.paddr[ADDR_LSB-1:0] == 2'b00)
                                 && (APB_REQ.paddr[31:ADDR_W+ADDR_LSB] == '0);
   wire              sel_thr   = aligned && (word_idx == ADDR_W'(IDX_SUPPLY_FAULT_THRESHOLD));
   wire              sel_clk   = aligned && (word_idx == ADDR_W'(IDX_BUCK_CLOCK_AND_TRACKING));
   wire              sel_out   = aligned && (word_idx == ADDR_W'(IDX_OUTPUT_AND_IF_CONTROL));
   wire              sel_bsw   = aligned && (word_idx == ADDR_W'(IDX_BUCK_SWITCH_AUTOENABLE));
   wire              sel_lbp   = aligned && (word_idx == ADDR_W'(IDX_LINEAR_BYPASS_AUTOENABLE));
   wire              sel_llo   = aligned && (word_idx == ADDR_W'(IDX_LINEAR_AUTOENABLE_LOW));
   wire              hit       = sel_thr | sel_clk | sel_out | sel_bsw | sel_lbp | sel_llo;
   wire              wr        = access & APB_REQ.pwrite;
   wire [7:0]        wbyte     = APB_REQ.pwdata[7:0];

   // All eight bits stored, reserved bit included
   assign thr_d = (wr && sel_thr) ? wbyte : thr_q;
   assign clk_d = (wr && sel_clk) ? wbyte : clk_q;
   assign out_d = (wr && sel_out) ? wbyte : out_q;
   assign bsw_d = (wr && sel_bsw) ? wbyte : bsw_q;
   assign lbp_d = (wr && sel_lbp) ? wbyte : lbp_q;
   assign llo_d = (wr && sel_llo) ? wbyte : llo_q;

   logic [7:0] rd_byte;
   always_comb begin
      if (sel_thr) begin
         rd_byte = thr_q;
      end else if (sel_clk) begin
         rd_byte = clk_q;
      end else if (sel_out) begin
         rd_byte = out_q;
      end else if (sel_bsw) begin
         rd_byte = bsw_q;
      end else if (sel_lbp) begin
         rd_byte = lbp_q;
      end else if (sel_llo) begin
         rd_byte = llo_q;
      end else begin
         rd_byte = 8'h00;
      end
   end
   // Read data captured in setup so it is stable from a flop during access
   assign rdata_d = (setup_ok && !APB_REQ.pwrite) ? {24'h0000_00, rd_byte} : rdata_q;

   // System enable reload on second OTP read unless kept
   assign sysen_d = (OTP_SECOND_READ && !out_q[SYSEN_KEEP_BIT]) ? OTP_SYSTEM_EN : sysen_q;

   // Deferred interrupt: event pending while low power, released in active mode
   wire defer = out_q[IRQ_DEFER_BIT] & LOW_POWER_STATE;
   assign irq_pend_d = defer ? (irq_pend_q | IRQ_EVENT) : 1'b0;
   assign irq_out_d  = defer ? 1'b0 : (IRQ_EVENT | irq_pend_q);

   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         thr_q      <= RST_SUPPLY_FAULT_THRESHOLD;
         clk_q      <= RST_BUCK_CLOCK_AND_TRACKING;
         out_q      <= RST_OUTPUT_AND_IF_CONTROL;
         bsw_q      <= RST_BUCK_SWITCH_AUTOENABLE;
         lbp_q      <= RST_LINEAR_BYPASS_AUTOENABLE;
         llo_q      <= RST_LINEAR_AUTOENABLE_LOW;
         sysen_q    <= 1'b0;
         irq_pend_q <= 1'b0;
         irq_out_q  <= 1'b0;
         rdata_q    <= 32'h0000_0000;
      end else begin
         thr_q      <= thr_d;
         clk_q      <= clk_d;
         out_q      <= out_d;
         bsw_q      <= bsw_d;
         lbp_q      <= lbp_d;
         llo_q      <= llo_d;
         sysen_q    <= sysen_d;
         irq_pend_q <= irq_pend_d;
         irq_out_q  <= irq_out_d;
         rdata_q    <= rdata_d;
      end
   end

   assign PREADY  = 1'b1;
   assign PSLVERR = access & ~hit;
   assign PRDATA  = rdata_q;

   assign FAULT_HYSTERESIS_MV      = code_to_mv(HYST_BASE_MV, {1'b0, thr_q[HYST_HI:HYST_LO]});
   assign FAULT_LOWER_THRESHOLD_MV = code_to_mv(LOWER_BASE_MV, thr_q[LOWER_HI:LOWER_LO]);

   // Bit 0 is core2, always the inverse of core1
   assign BUCK_CLOCK_INVERT     = {clk_q[CLKINV_HI:CLKINV_LO], ~clk_q[CORE1_INV_BIT]};
   assign RAIL_DISCHARGE_ENABLE = clk_q[DISCHARGE_BIT];
   // Processor vs memory polarity left to software, not enforced
   assign LINEAR1_TRACKING_SELECT = psc_track_t'(clk_q[TRACK_HI:TRACK_LO]);

   // Raw feedback is active high; output inverted unless polarity bit set
   assign FEEDBACK_OUT3 = out_q[FB3_POL_BIT] ? FEEDBACK_OUT3_RAW : ~FEEDBACK_OUT3_RAW;
   // Open drain drives only low; push-pull drives always
   assign FEEDBACK_OUT2_O  = out_q[FB2_POL_BIT] ? 1'b0 : ~FEEDBACK_OUT2_RAW;
   assign FEEDBACK_OUT2_OE = out_q[FB2_POL_BIT] ? ~FEEDBACK_OUT2_RAW : 1'b1;

   assign SYSTEM_RESET_OUT_N              = ~out_q[FORCE_RESET_BIT];
   assign SECOND_BUS_HIGHSPEED_CONTINUOUS = out_q[HSM_BIT];
   assign SECOND_BUS_FASTPLUS_SELECT      = out_q[FMP_BIT];
   assign SYSTEM_EN                       = sysen_q;
   assign INTERRUPT_OUT                   = irq_out_q;

   // Autoenable forces rail on during power-up, else own config
   assign BUCK_SWITCH_ENABLE   = (POWERING_UP ? bsw_q : 8'h00) | BUCK_SWITCH_CONF_EN;
   assign LINEAR_BYPASS_SELECT = lbp_q[BYPASS_HI:BYPASS_LO];
   assign LINEAR_ENABLE = (POWERING_UP ? {lbp_q[LIN_HI_AUTO_HI:LIN_HI_AUTO_LO], llo_q} : 11'h000)
                          | LINEAR_CONF_EN;

endmodule
`default_nettype wire

//--- psc_bank_assertions.sv
// Port-level assertions for the startup configuration bank
`timescale 1ns/100ps
`default_nettype none
module psc_bank_chk
   import psc_pkg::*;
(
   input wire logic         CORE_CLK, RSTN, POWERING_UP, IRQ_EVENT, LOW_POWER_STATE,
   input wire logic         INTERRUPT_OUT, SYSTEM_RESET_OUT_N,
   input wire psc_apb_req_t APB_REQ,
   input wire logic [5:0]   BUCK_CLOCK_INVERT,
   input wire logic [7:0]   BUCK_SWITCH_CONF_EN, BUCK_SWITCH_ENABLE,
   input wire logic [10:0]  LINEAR_CONF_EN, LINEAR_ENABLE,
   input wire logic [11:0]  FAULT_HYSTERESIS_MV
);
   default clocking dc @(posedge CORE_CLK); endclocking
   default disable iff (!RSTN);
   sequence s_wr(logic [31:0] a);
      APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite && APB_REQ.paddr == a;
   endsequence
   property p_hyst; s_wr(32'h0000_041C) |=> FAULT_HYSTERESIS_MV == 12'h064 + 12'h032 * 12'($past(APB_REQ.pwdata[6:4])); endproperty
   a_hyst: assert property (p_hyst) else $error("hysteresis code");
   property p_core2; BUCK_CLOCK_INVERT[0] == !BUCK_CLOCK_INVERT[1]; endproperty
   a_core2: assert property (p_core2) else $error("core2 polarity");
   property p_rst; s_wr(32'h0000_0424) |=> SYSTEM_RESET_OUT_N == !$past(APB_REQ.pwdata[5]); endproperty
   a_rst: assert property (p_rst) else $error("forced reset");
   property p_irq; IRQ_EVENT && !LOW_POWER_STATE |=> INTERRUPT_OUT; endproperty
   a_irq: assert property (p_irq) else $error("interrupt late");
   property p_bsw; !POWERING_UP |-> BUCK_SWITCH_ENABLE == BUCK_SWITCH_CONF_EN; endproperty
   a_bsw: assert property (p_bsw) else $error("buck enable idle");
   property p_bup; POWERING_UP |-> (BUCK_SWITCH_ENABLE & BUCK_SWITCH_CONF_EN) == BUCK_SWITCH_CONF_EN; endproperty
   a_bup: assert property (p_bup) else $error("buck enable lost");
   property p_lin; !POWERING_UP |-> LINEAR_ENABLE == LINEAR_CONF_EN; endproperty
   a_lin: assert property (p_lin) else $error("linear enable idle");
   property p_lup; POWERING_UP |-> (LINEAR_ENABLE & LINEAR_CONF_EN) == LINEAR_CONF_EN; endproperty
   a_lup: assert property (p_lup) else $error("linear enable lost");
endmodule
bind psc_config_bank psc_bank_chk chk_u (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .POWERING_UP(POWERING_UP),
   .IRQ_EVENT(IRQ_EVENT), .LOW_POWER_STATE(LOW_POWER_STATE), .INTERRUPT_OUT(INTERRUPT_OUT),
   .SYSTEM_RESET_OUT_N(SYSTEM_RESET_OUT_N), .APB_REQ(APB_REQ), .BUCK_CLOCK_INVERT(BUCK_CLOCK_INVERT),
   .BUCK_SWITCH_CONF_EN(BUCK_SWITCH_CONF_EN), .BUCK_SWITCH_ENABLE(BUCK_SWITCH_ENABLE),
   .LINEAR_CONF_EN(LINEAR_CONF_EN), .LINEAR_ENABLE(LINEAR_ENABLE), .FAULT_HYSTERESIS_MV(FAULT_HYSTERESIS_MV));
`default_nettype wire

//--- psc_host.sv
// Host software model driving the bank over APB
`timescale 1ns/100ps
`default_nettype none
module psc_host
   import psc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic [31:0] prdata,
   output var psc_apb_req_t req
);
   logic hang = 1'b0;
   initial req = '0;
   // Released lines carry inverted data so a stale value never reads as valid
   task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q, output logic e);
      int n;
      @(posedge clk) req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk) req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      hang = (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      req <= '{1'b0, 1'b0, ~w, ~a, ~d};
   endtask
endmodule
`default_nettype wire

//--- pmic_startup_config_bank_bench.sv
// Self-checking bench for the startup configuration bank
`timescale 1ns/100ps
`default_nettype none
module pmic_startup_config_bank_bench
   import psc_pkg::*;
;
   logic clk = 1'b0, rstn = 1'b0, pwr_up = 1'b0, low_pwr = 1'b0, otp_rd = 1'b0, otp_en = 1'b1, irq_ev = 1'b0;
   logic fb2_raw = 1'b0, fb3_raw = 1'b1, pready, pslverr, dis, fb3, fb2o, fb2oe, rst_n, hsm, fmp, sys_en, irq_out;
   logic [7:0] bsw_conf = 8'h10, bsw_en;
   logic [10:0] lin_conf = 11'h004, lin_en;
   logic [11:0] hys, lowt;
   logic [5:0] inv;
   logic [4:0] byp;
   logic [31:0] prdata;
   psc_track_t trk;
   psc_apb_req_t req;
   int fail_count = 0, tests_run = 0;
   // Processor polarity opposite memory polarity
   logic [7:0] dv [6] = '{8'hFF, 8'h9E, 8'hFA, 8'h81, 8'hA9, 8'h42};
   always #12.5 clk = ~clk;
   psc_host host_u (.clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .req(req));
   psc_config_bank dut_u (.CORE_CLK(clk), .RSTN(rstn), .APB_REQ(req), .PREADY(pready), .PSLVERR(pslverr),
      .PRDATA(prdata), .POWERING_UP(pwr_up), .LOW_POWER_STATE(low_pwr), .OTP_SECOND_READ(otp_rd),
      .OTP_SYSTEM_EN(otp_en), .IRQ_EVENT(irq_ev), .FEEDBACK_OUT2_RAW(fb2_raw), .FEEDBACK_OUT3_RAW(fb3_raw),
      .BUCK_SWITCH_CONF_EN(bsw_conf), .LINEAR_CONF_EN(lin_conf), .FAULT_HYSTERESIS_MV(hys),
      .FAULT_LOWER_THRESHOLD_MV(lowt), .BUCK_CLOCK_INVERT(inv), .RAIL_DISCHARGE_ENABLE(dis),
      .LINEAR1_TRACKING_SELECT(trk), .FEEDBACK_OUT3(fb3), .FEEDBACK_OUT2_O(fb2o), .FEEDBACK_OUT2_OE(fb2oe),
      .SYSTEM_RESET_OUT_N(rst_n), .SECOND_BUS_HIGHSPEED_CONTINUOUS(hsm), .SECOND_BUS_FASTPLUS_SELECT(fmp),
      .SYSTEM_EN(sys_en), .INTERRUPT_OUT(irq_out), .BUCK_SWITCH_ENABLE(bsw_en), .LINEAR_BYPASS_SELECT(byp),
      .LINEAR_ENABLE(lin_en));
   function automatic logic [31:0] ad(input int i);
      return {18'h0_0000, IDX_SUPPLY_FAULT_THRESHOLD, 2'b00} + 32'(4 * i);
   endfunction
   task automatic chk(input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic acc(input logic w, input logic [31:0] a, d, x, input logic xe);
      logic [31:0] q;
      logic e;
      host_u.xfer(w, a, d, q, e);
      if (host_u.hang) begin
         fail_count++;
         close_out();
      end
      if (!w) chk(q, x);
      chk(32'(e), 32'(xe));
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 6; i++) acc(1'b0, ad(i), '0, '0, 1'b0);
      acc(1'b0, 32'h0000_0434, '0, '0, 1'b1);
      $display("reset test done");
      for (int i = 0; i < 6; i++) acc(1'b1, ad(i), {24'hFF_FFFF, dv[i]}, '0, 1'b0);
      for (int i = 0; i < 6; i++) acc(1'b0, ad(i), '0, 32'(dv[i]), 1'b0);
      chk(32'(hys), 32'h0000_01C2);
      chk(32'(lowt), 32'h0000_0CB2);
      chk(32'({inv, dis}), 32'h0000_004D);
      chk(32'({fb3, fb2o, fb2oe, rst_n, hsm, fmp}), 32'h0000_002B);
      chk(32'(byp), 32'h0000_0015);
      @(posedge clk) pwr_up <= 1'b1;
      @(negedge clk) chk(32'({bsw_en, lin_en}), 32'h0004_8946);
      @(posedge clk) pwr_up <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         acc(1'b1, ad(1), 32'(8'h9C | 8'(k)), '0, 1'b0);
         // Write lands on the edge the task returns at; look once it has settled
         @(negedge clk) chk(32'(trk), 32'(k));
      end
      @(posedge clk) otp_rd <= 1'b1;
      @(posedge clk) otp_rd <= 1'b0;
      @(negedge clk) chk(32'(sys_en), 32'h1);
      $display("decode test done");
      @(posedge clk) low_pwr <= 1'b1;
      irq_ev <= 1'b1;
      @(posedge clk) irq_ev <= 1'b0;
      repeat (2) @(negedge clk);
      chk(32'(irq_out), 32'h0);
      @(posedge clk) low_pwr <= 1'b0;
      @(posedge clk);
      @(negedge clk) chk(32'(irq_out), 32'h1);
      @(negedge clk) chk(32'(irq_out), 32'h0);
      acc(1'b1, ad(2), 32'h0000_0004, '0, 1'b0);
      otp_en <= 1'b0;
      otp_rd <= 1'b1;
      @(posedge clk) otp_rd <= 1'b0;
      @(negedge clk) chk(32'({sys_en, fb3, fb2o, fb2oe, rst_n, hsm, fmp}), 32'h0000_005C);
      @(posedge clk) low_pwr <= 1'b1;
      irq_ev <= 1'b1;
      @(posedge clk) low_pwr <= 1'b0;
      @(negedge clk) chk(32'(irq_out), 32'h1);
      @(posedge clk) irq_ev <= 1'b0;
      $display("control test done");
      close_out();
   end
endmodule
`default_nettype wire
